// ### src/uspc_pkg.sv
// Purpose: Shared constants and types for the serial port control block
// Assumes: Byte-wide special-function space, 16x baud tick from a timer
// Notes:   Bit positions index the serial_port_control register
package uspc_pkg;

    localparam logic [7:0] ADDR_CTRL     = 8'h98;
    localparam logic [7:0] ADDR_DATA     = 8'h99;
    localparam logic [7:0] CTRL_RESET    = 8'h40;
    localparam logic [7:0] DATA_RESET    = 8'h00;

    localparam int BIT_FRAME_SEL  = 7;
    localparam int BIT_RESERVED   = 6;
    localparam int BIT_MULTIDROP  = 5;
    localparam int BIT_RX_ENABLE  = 4;
    localparam int BIT_TX_NINTH   = 3;
    localparam int BIT_RX_NINTH   = 2;
    localparam int BIT_TX_DONE    = 1;
    localparam int BIT_RX_DONE    = 0;

    // Last of the 16 baud ticks in a bit time, and the tick that marks mid-bit
    localparam logic [3:0] TICK_LAST  = 4'hF;
    localparam logic [3:0] TICK_MID   = 4'h7;
    localparam logic [2:0] DATA_LAST  = 3'h7;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       bit_wr;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] bit_addr;
        logic       bit_val;
    } uspc_sfr_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       ninth;
    } uspc_rx_frame_t;

    typedef enum logic [2:0] {
        USPC_IDLE,
        USPC_START,
        USPC_DATA,
        USPC_NINTH,
        USPC_STOP
    } uspc_state_t;

endpackage

// ### src/uspc_rx.sv
// Purpose: Receive framer: finds start bit, samples data mid-bit
// Assumes: baud_tick is a one-cycle pulse at 16x the bit rate
// Notes:   Acceptance of the frame is decided by the control logic
`timescale 1ns/100ps
module uspc_rx (
    input  wire logic                     clk,
    input  wire logic                     reset,
    input  wire logic                     baud_tick,
    input  wire logic                     rx_enable,
    input  wire logic                     nine_bit,
    input  wire logic                     rx_pin,
    output uspc_pkg::uspc_rx_frame_t      frame
);

    logic                  sync1_r;
    logic                  sync2_r;
    logic                  line_prev_r;
    uspc_pkg::uspc_state_t state_r;
    uspc_pkg::uspc_state_t state_nxt;
    logic [3:0]            tick_r;
    logic [3:0]            tick_nxt;
    logic [2:0]            bit_r;
    logic [2:0]            bit_nxt;
    logic [7:0]            shift_r;
    logic [7:0]            shift_nxt;
    logic                  ninth_r;
    logic                  ninth_nxt;
    uspc_pkg::uspc_rx_frame_t frame_r;
    uspc_pkg::uspc_rx_frame_t frame_nxt;
    logic                  sample;

    assign frame = frame_r;

    always_comb begin
        state_nxt = state_r;
        tick_nxt  = tick_r;
        bit_nxt   = bit_r;
        shift_nxt = shift_r;
        ninth_nxt = ninth_r;
        frame_nxt = '{valid: 1'b0, data: frame_r.data, ninth: frame_r.ninth};
        sample    = 1'b0;
        if (baud_tick && state_r != uspc_pkg::USPC_IDLE) begin
            tick_nxt = tick_r + 4'h1;
            if (state_r == uspc_pkg::USPC_START) begin
                sample = (tick_r == uspc_pkg::TICK_MID);
            end else begin
                sample = (tick_r == uspc_pkg::TICK_LAST);
            end
            if (sample) begin
                tick_nxt = 4'h0;
            end
        end
        case (state_r)
            uspc_pkg::USPC_IDLE: begin
                // Falling edge of the synchronised line opens a frame
                if (rx_enable && line_prev_r && !sync2_r) begin
                    state_nxt = uspc_pkg::USPC_START;
                    tick_nxt  = 4'h0;
                end
            end
            uspc_pkg::USPC_START: begin
                // A glitch that is high again at mid-bit is not a start
                if (sample) begin
                    state_nxt = sync2_r ? uspc_pkg::USPC_IDLE
                                        : uspc_pkg::USPC_DATA;
                    bit_nxt   = 3'h0;
                end
            end
            uspc_pkg::USPC_DATA: begin
                if (sample) begin
                    shift_nxt = {sync2_r, shift_r[7:1]};
                    bit_nxt   = bit_r + 3'h1;
                    if (bit_r == uspc_pkg::DATA_LAST) begin
                        state_nxt = nine_bit ? uspc_pkg::USPC_NINTH
                                             : uspc_pkg::USPC_STOP;
                    end
                end
            end
            uspc_pkg::USPC_NINTH: begin
                if (sample) begin
                    ninth_nxt = sync2_r;
                    state_nxt = uspc_pkg::USPC_STOP;
                end
            end
            uspc_pkg::USPC_STOP: begin
                if (sample) begin
                    // Stop bit stands in for the ninth bit in 8-bit frames
                    frame_nxt.valid = 1'b1;
                    frame_nxt.data  = shift_r;
                    frame_nxt.ninth = nine_bit ? ninth_r : sync2_r;
                    state_nxt       = uspc_pkg::USPC_IDLE;
                end
            end
            default: state_nxt = uspc_pkg::USPC_IDLE;
        endcase
        if (!rx_enable) begin
            state_nxt = uspc_pkg::USPC_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sync1_r     <= 1'b1;
            sync2_r     <= 1'b1;
            line_prev_r <= 1'b1;
            state_r     <= uspc_pkg::USPC_IDLE;
            tick_r      <= 4'h0;
            bit_r       <= 3'h0;
            shift_r     <= 8'h00;
            ninth_r     <= 1'b0;
            frame_r     <= '0;
        end else begin
            sync1_r     <= rx_pin;
            sync2_r     <= sync1_r;
            line_prev_r <= sync2_r;
            state_r     <= state_nxt;
            tick_r      <= tick_nxt;
            bit_r       <= bit_nxt;
            shift_r     <= shift_nxt;
            ninth_r     <= ninth_nxt;
            frame_r     <= frame_nxt;
        end
    end

endmodule

// ### src/uspc_top.sv
// Purpose: Serial port control register, data buffer, transmitter
// Assumes: Processor reaches registers over the special-function port
// Notes:   Interrupt enable lives in the processor, not here
// Notes on behaviour
// - Bit 7 selects 8-bit or 9-bit frames
// - Multidrop 8-bit: stop bit must be one
// - Multidrop 9-bit: accept only ninth bit one
// - Multidrop off: ninth or stop bit ignored
// - Receive enable bit 4 gates all reception
// - Bit 3 sent as ninth bit, 9-bit only
// - Bit 2 captures stop or ninth bit
// - Transmit-done set at start of stop bit
// - Set transmit-done raises the interrupt request
// - Only software clears transmit-done
// - Control at 0x98, bit-writable except read-only bit 6
// - Start, eight data LSB first, ninth in 9-bit mode only, stop
// - Load latch only if receive-done clear, check passes
// - Receive-done set at stop sample, software clears
// - Buffer write transmits, buffer read returns latch
`timescale 1ns/100ps
module uspc_top (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic                   baud_tick,
    input  wire uspc_pkg::uspc_sfr_req_t sfr_req,
    output logic [7:0]                  sfr_rdata_r,
    output logic                        serial_irq_r,
    input  wire logic                   rx_pin,
    output logic                        tx_line_r
);

    logic [7:0]               ctrl_r;
    logic [7:0]               ctrl_nxt;
    logic [7:0]               rx_latch_r;
    logic [7:0]               rx_latch_nxt;
    logic [7:0]               rdata_nxt;
    uspc_pkg::uspc_rx_frame_t frame;
    logic                     accept;
    logic                     tx_done_set;
    logic                     data_wr;
    logic                     ctrl_bit_hit;

    uspc_pkg::uspc_state_t    tx_state_r;
    uspc_pkg::uspc_state_t    tx_state_nxt;
    logic [3:0]               tx_tick_r;
    logic [3:0]               tx_tick_nxt;
    logic [2:0]               tx_bit_r;
    logic [2:0]               tx_bit_nxt;
    logic [7:0]               tx_shift_r;
    logic [7:0]               tx_shift_nxt;
    logic                     tx_ninth_r;
    logic                     tx_ninth_nxt;
    logic                     tx_line_nxt;
    logic                     bit_end;

    uspc_rx u_rx (
        .clk       (clk),
        .reset     (reset),
        .baud_tick (baud_tick),
        .rx_enable (ctrl_r[uspc_pkg::BIT_RX_ENABLE]),
        .nine_bit  (ctrl_r[uspc_pkg::BIT_FRAME_SEL]),
        .rx_pin    (rx_pin),
        .frame     (frame)
    );

    assign data_wr      = sfr_req.wr && sfr_req.addr == uspc_pkg::ADDR_DATA;
    assign ctrl_bit_hit = sfr_req.bit_wr &&
                          sfr_req.bit_addr[7:3] == uspc_pkg::ADDR_CTRL[7:3];

    // Multidrop check: ninth field holds stop bit or ninth bit per mode
    always_comb begin
        accept = frame.valid && !ctrl_r[uspc_pkg::BIT_RX_DONE] &&
                 (!ctrl_r[uspc_pkg::BIT_MULTIDROP] ||
                  frame.ninth);
    end

    // Control register: software first, hardware sets override it
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (sfr_req.wr && sfr_req.addr == uspc_pkg::ADDR_CTRL) begin
            ctrl_nxt = sfr_req.wdata;
        end
        for (int i = 0; i < 8; i++) begin
            if (ctrl_bit_hit && sfr_req.bit_addr[2:0] == 3'(i)) begin
                ctrl_nxt[i] = sfr_req.bit_val;
            end
        end
        // Read-only bit ignores whatever software writes there
        ctrl_nxt[uspc_pkg::BIT_RESERVED] =
            uspc_pkg::CTRL_RESET[uspc_pkg::BIT_RESERVED];
        if (tx_done_set) begin
            ctrl_nxt[uspc_pkg::BIT_TX_DONE] = 1'b1;
        end
        rx_latch_nxt = rx_latch_r;
        if (accept) begin
            ctrl_nxt[uspc_pkg::BIT_RX_DONE]  = 1'b1;
            ctrl_nxt[uspc_pkg::BIT_RX_NINTH] = frame.ninth;
            rx_latch_nxt                     = frame.data;
        end
        rdata_nxt = sfr_rdata_r;
        if (sfr_req.rd) begin
            if (sfr_req.addr == uspc_pkg::ADDR_CTRL) begin
                rdata_nxt = ctrl_r;
            end else if (sfr_req.addr == uspc_pkg::ADDR_DATA) begin
                rdata_nxt = rx_latch_r;
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    // Transmitter; a buffer write while busy restarts the frame
    always_comb begin
        tx_state_nxt = tx_state_r;
        tx_tick_nxt  = tx_tick_r;
        tx_bit_nxt   = tx_bit_r;
        tx_shift_nxt = tx_shift_r;
        tx_ninth_nxt = tx_ninth_r;
        tx_line_nxt  = tx_line_r;
        tx_done_set  = 1'b0;
        bit_end      = 1'b0;
        if (baud_tick && tx_state_r != uspc_pkg::USPC_IDLE) begin
            tx_tick_nxt = tx_tick_r + 4'h1;
            bit_end     = (tx_tick_r == uspc_pkg::TICK_LAST);
        end
        case (tx_state_r)
            uspc_pkg::USPC_IDLE: tx_line_nxt = 1'b1;
            uspc_pkg::USPC_START: begin
                if (bit_end) begin
                    tx_state_nxt = uspc_pkg::USPC_DATA;
                    tx_line_nxt  = tx_shift_r[0];
                    tx_bit_nxt   = 3'h0;
                end
            end
            uspc_pkg::USPC_DATA: begin
                if (bit_end) begin
                    tx_bit_nxt   = tx_bit_r + 3'h1;
                    tx_shift_nxt = {1'b0, tx_shift_r[7:1]};
                    tx_line_nxt  = tx_shift_r[1];
                    if (tx_bit_r == uspc_pkg::DATA_LAST) begin
                        if (ctrl_r[uspc_pkg::BIT_FRAME_SEL]) begin
                            tx_state_nxt = uspc_pkg::USPC_NINTH;
                            tx_line_nxt  = tx_ninth_r;
                        end else begin
                            tx_state_nxt = uspc_pkg::USPC_STOP;
                            tx_line_nxt  = 1'b1;
                            tx_done_set  = 1'b1;
                        end
                    end
                end
            end
            uspc_pkg::USPC_NINTH: begin
                if (bit_end) begin
                    tx_state_nxt = uspc_pkg::USPC_STOP;
                    tx_line_nxt  = 1'b1;
                    tx_done_set  = 1'b1;
                end
            end
            uspc_pkg::USPC_STOP: begin
                if (bit_end) begin
                    tx_state_nxt = uspc_pkg::USPC_IDLE;
                end
            end
            default: tx_state_nxt = uspc_pkg::USPC_IDLE;
        endcase
        if (data_wr) begin
            tx_state_nxt = uspc_pkg::USPC_START;
            tx_shift_nxt = sfr_req.wdata;
            tx_ninth_nxt = ctrl_r[uspc_pkg::BIT_TX_NINTH];
            tx_tick_nxt  = 4'h0;
            tx_line_nxt  = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_r       <= uspc_pkg::CTRL_RESET;
            rx_latch_r   <= uspc_pkg::DATA_RESET;
            sfr_rdata_r  <= 8'h00;
            serial_irq_r <= 1'b0;
            tx_state_r   <= uspc_pkg::USPC_IDLE;
            tx_tick_r    <= 4'h0;
            tx_bit_r     <= 3'h0;
            tx_shift_r   <= 8'h00;
            tx_ninth_r   <= 1'b0;
            tx_line_r    <= 1'b1;
        end else begin
            ctrl_r       <= ctrl_nxt;
            rx_latch_r   <= rx_latch_nxt;
            sfr_rdata_r  <= rdata_nxt;
            // Level request; processor applies its own enable
            serial_irq_r <= ctrl_nxt[uspc_pkg::BIT_TX_DONE] |
                            ctrl_nxt[uspc_pkg::BIT_RX_DONE];
            tx_state_r   <= tx_state_nxt;
            tx_tick_r    <= tx_tick_nxt;
            tx_bit_r     <= tx_bit_nxt;
            tx_shift_r   <= tx_shift_nxt;
            tx_ninth_r   <= tx_ninth_nxt;
            tx_line_r    <= tx_line_nxt;
        end
    end

endmodule

// ### sim/uspc_assertions.sv
// Purpose: Port-level checks for the serial port control block
// Assumes: One clock, synchronous active-high reset, bench writes one
//          request at a time with a free cycle between requests
// Notes:   Bound to every uspc_top instance
`timescale 1ns/100ps
module uspc_assertions (
    input wire logic                    clk,
    input wire logic                    reset,
    input wire logic                    baud_tick,
    input wire uspc_pkg::uspc_sfr_req_t sfr_req,
    input wire logic [7:0]              sfr_rdata_r,
    input wire logic                    serial_irq_r,
    input wire logic                    rx_pin,
    input wire logic                    tx_line_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    logic       dwr;
    logic       cwr;
    logic       rdc;
    logic       sw;
    logic [7:0] idle_r;
    logic [7:0] idle_nxt;

    assign dwr = sfr_req.wr && sfr_req.addr == 8'h99 && !sfr_req.bit_wr;
    assign cwr = sfr_req.wr && sfr_req.addr == 8'h98 && !sfr_req.bit_wr;
    assign rdc = sfr_req.rd && sfr_req.addr == 8'h98;
    assign sw  = sfr_req.wr || sfr_req.bit_wr;

    // Baud ticks since the last data write, saturating past a full frame
    always_comb begin
        idle_nxt = idle_r;
        if (reset) begin
            idle_nxt = 8'hC8;
        end else if (dwr) begin
            idle_nxt = 8'h00;
        end else if (baud_tick && idle_r != 8'hC8) begin
            idle_nxt = idle_r + 8'h01;
        end
    end
    always_ff @(posedge clk) begin
        idle_r <= idle_nxt;
    end

    a_reset_idle_lines: assert property ($fell(reset) |->
        tx_line_r && !serial_irq_r && sfr_rdata_r == 8'h00)
        else $error("outputs not idle after reset");
    a_start_bit_low: assert property (dwr |=> !tx_line_r [*3])
        else $error("start bit missing after data write");
    a_line_idle_high: assert property (idle_r > 8'hB4 |-> tx_line_r)
        else $error("transmit line low outside a frame");
    a_reserved_reads_one: assert property (rdc |=> sfr_rdata_r[6])
        else $error("reserved control bit read as zero");
    a_unmapped_zero: assert property (sfr_req.rd &&
        sfr_req.addr[7:1] != 7'h4C |=> sfr_rdata_r == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!sfr_req.rd |=>
        $stable(sfr_rdata_r))
        else $error("read data changed without a read");
    a_flag_sw_clear: assert property ($fell(serial_irq_r) |->
        $past(sw) || $past(sw, 2))
        else $error("flag cleared without software write");
    a_ctrl_readback: assert property (cwr ##2 rdc |=>
        (sfr_rdata_r & 8'hB8) == ($past(sfr_req.wdata, 3) & 8'hB8))
        else $error("control bits not as written");

    c_data_write: cover property (dwr);
    c_irq_rise: cover property ($rose(serial_irq_r));
    c_rx_flag_read: cover property (rdc ##1 sfr_rdata_r[0]);
    // Remote station opening a frame toward the receiver
    c_rx_start: cover property ($fell(rx_pin));
endmodule

bind uspc_top uspc_assertions u_chk (
    .clk(clk), .reset(reset), .baud_tick(baud_tick), .sfr_req(sfr_req),
    .sfr_rdata_r(sfr_rdata_r), .serial_irq_r(serial_irq_r),
    .rx_pin(rx_pin), .tx_line_r(tx_line_r)
);

// ### sim/uspc_remote.sv
// Purpose: Remote serial station facing the port's line pins
// Assumes: 16 baud ticks per bit time
// Notes:   Captured frames hold ten line samples after the start bit
`timescale 1ns/100ps
module uspc_remote (
    input wire logic clk,
    input wire logic baud_tick,
    input wire logic tx_line,
    output logic     rx_pin
);
    logic [9:0] got_q[$];
    logic [9:0] v;

    initial rx_pin = 1'b1;

    task automatic ticks(input int n);
        repeat (n) @(posedge clk iff baud_tick);
    endtask

    task automatic send(input logic [8:0] d, input logic nine,
                        input logic stop);
        @(posedge clk);
        rx_pin <= 1'b0;
        ticks(16);
        for (int i = 0; i < 9; i++) begin
            if (i < 8 || nine) begin
                rx_pin <= d[i];
                ticks(16);
            end
        end
        rx_pin <= stop;
        ticks(16);
        rx_pin <= 1'b1;
    endtask

    // Samples mid-bit; in 8-bit frames the tenth sample sees idle line
    always begin
        @(negedge tx_line);
        ticks(8);
        for (int i = 0; i < 10; i++) begin
            ticks(16);
            v[i] = tx_line;
        end
        got_q.push_back(v);
    end
endmodule

// ### sim/uart_serial_port_control_tb_top.sv
// Purpose: Self-checking bench for the serial port control block
// Assumes: Baud tick every second clock, remote station on the line
// Notes:   Model keeps control byte and receive latch as plain values
`timescale 1ns/100ps
module uart_serial_port_control_tb_top;
    logic                    clk;
    logic                    reset;
    logic                    baud_tick;
    logic                    rx_pin;
    logic                    tx_line_r;
    logic                    irq;
    uspc_pkg::uspc_sfr_req_t req;
    logic [7:0]              rdata;
    logic [7:0]              ctrl_m;
    logic [7:0]              dat_m;
    logic [31:0]             seed;
    logic [4:0]              c;
    int                      n;
    int                      n_fail;
    int                      checked;
    // Entries: mode, multidrop, enable, ninth or stop level, clear after
    logic [4:0] cases [9] = '{5'b00011, 5'b00101, 5'b01101, 5'b01111,
        5'b11101, 5'b11111, 5'b10101, 5'b00110, 5'b00111};

    uspc_top dut (.clk(clk), .reset(reset), .baud_tick(baud_tick),
        .sfr_req(req), .sfr_rdata_r(rdata), .serial_irq_r(irq),
        .rx_pin(rx_pin), .tx_line_r(tx_line_r));
    uspc_remote remote (.clk(clk), .baud_tick(baud_tick),
        .tx_line(tx_line_r), .rx_pin(rx_pin));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        baud_tick <= !reset && !baud_tick;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // k selects write, read, bit write; bit value rides in d[0]
    task automatic bus(input logic [2:0] k, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: k[2], rd: k[1], bit_wr: k[0], addr: a, wdata: d,
                 bit_addr: a, bit_val: d[0]};
        @(posedge clk);
        req <= '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        bus(3'b010, a, 8'h00);
        @(posedge clk);
        #1 chk({2'b00, rdata}, {2'b00, exp});
    endtask

    task automatic set_ctrl(input logic [7:0] v);
        bus(3'b100, 8'h98, v | 8'h40);
        ctrl_m = v | 8'h40;
        rd(8'h98, ctrl_m);
    endtask

    task automatic close_out();
        $display("checks %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        close_out();
    end

    initial begin
        req = '0;
        reset = 1'b1;
        baud_tick = 1'b0;
        seed = 32'h2204;
        n_fail = 0;
        checked = 0;
        ctrl_m = 8'h40;
        dat_m = 8'h00;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        rd(8'h98, 8'h40);
        rd(8'h99, 8'h00);
        rd(8'h9A, 8'h00);
        bus(3'b001, 8'h9E, 8'h00);
        rd(8'h98, 8'h40);
        for (int k = 3; k < 8; k++) begin
            if (k != 6) begin
                bus(3'b001, 8'(8'h98 + k), 8'h01);
                rd(8'h98, 8'(8'h40 | (8'h01 << k)));
                bus(3'b001, 8'(8'h98 + k), 8'h00);
            end
        end
        for (int m = 0; m < 2; m++) begin
            seed = xs(seed);
            set_ctrl(8'(m * 128 + seed[8] * 8));
            bus(3'b100, 8'h99, seed[7:0]);
            n = 0;
            while (irq !== 1'b1 && n < 1000) begin
                @(posedge clk);
                n++;
            end
            chk(10'(n > 283 + m * 32 && n < 293 + m * 32), 10'h001);
            chk(10'(tx_line_r), 10'h001);
            n = 0;
            while (remote.got_q.size() == 0 && n < 400) begin
                @(posedge clk);
                n++;
            end
            chk(remote.got_q.pop_front(),
                {1'b1, m == 1 ? seed[8] : 1'b1, seed[7:0]});
            ctrl_m[1] = 1'b1;
            rd(8'h98, ctrl_m);
            chk(10'(irq), 10'h001);
            bus(3'b001, 8'h99, 8'h00);
            ctrl_m[1] = 1'b0;
            rd(8'h98, ctrl_m);
            chk(10'(irq), 10'h000);
        end
        foreach (cases[i]) begin
            c = cases[i];
            seed = xs(seed);
            set_ctrl({c[4], 1'b1, c[3], c[2], 1'b0, ctrl_m[2:0]});
            remote.send({c[1], seed[7:0]}, c[4], c[4] | c[1]);
            if (c[2] && !ctrl_m[0] && (!c[3] || c[1])) begin
                ctrl_m[0] = 1'b1;
                ctrl_m[2] = c[1];
                dat_m = seed[7:0];
            end
            repeat (4) @(posedge clk);
            rd(8'h98, ctrl_m);
            rd(8'h99, dat_m);
            chk(10'(irq), 10'(ctrl_m[0]));
            if (c[0]) begin
                bus(3'b001, 8'h98, 8'h00);
                ctrl_m[0] = 1'b0;
            end
        end
        close_out();
    end
endmodule
